/* File: rws_sequencer.sv */
`timescale 1ns/1ps
// Functional notes
// RQ1 - stop wake counts prescaler, clocks stay off for 4096 or 32 cycles
// RQ2 - light sleep stops core clock, module clocks keep running
// RQ3 - every source asserts internal reset, vector fffe or fefe in monitor mode
// RQ4 - during internal reset all registers return to defaults
// RQ5 - internal resets clear the prescaler, a pin reset leaves it alone
// RQ6 - each source sets its own cause flag
// RQ7 - pin flag needs 67 low cycles, or 4163 after power-on or low voltage
// RQ8 - internal reset drives pin low 32 cycles, then holds 32 more
// RQ9 - power-on and low voltage first count 4096 cycles with pin low
// RQ10 - power-up holds pin low 4096 cycles, releases core 64 later
// RQ11 - power-up keeps bus clock source on, core and modules off 4096 cycles
// RQ12 - power-up sets power-on flag and clears the others
// RQ13 - watchdog overflow, asynchronous, resets and sets watchdog flag
// RQ14 - write to ffff clears watchdog and prescaler bits 12 to 4
// RQ15 - prescaler overflow ticks the watchdog once every 8192 cycles
// RQ16 - watchdog off on high voltage pins in monitor mode or break; in break only the reset pin high voltage turns it off
// RQ17 - illegal instruction sets opcode flag and resets
// RQ18 - deep sleep instruction with halt not allowed is an illegal opcode
// RQ19 - only opcode fetch from unmapped address resets and sets address flag
// RQ20 - low voltage sets its flag, pin low 4096, core free 64 later
// RQ21 - 13 bit prescaler on reference falling edge, overflow feeds watchdog
// RQ22 - deep sleep clears prescaler, wake delay 32 if short option else 4096
// RQ23 - reset pin synchronised before timing its low duration
module rws_sequencer #(
	parameter int PIN_MIN_LONG_CYC = rws_pkg::RWS_PIN_MIN_LONG_CYC
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_we_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic por_i,
	input wire logic lvd_i,
	input wire logic wdt_ovf_i,
	input wire logic rst_pin_i,
	input wire logic rst_hv_i,
	input wire logic irq_hv_i,
	input wire logic wake_i,
	input wire rws_pkg::rws_core_s core_i,
	output logic rst_pin_o,
	output logic rst_pin_oe_o,
	output logic internal_reset_o,
	output logic [15:0] vector_addr_o,
	output logic core_clk_en_o,
	output logic module_clk_en_o,
	output logic bus_clock_source_en_o,
	output logic wdt_tick_o,
	output logic wdt_clear_o,
	output logic wdt_enable_o
);

	////////////////////////////////////////////////////////////////////////////
	// derived cycle limits
	localparam logic [12:0] LONG_LAST = 13'(rws_pkg::RWS_LONG_CYC - 1);
	localparam logic [12:0] SHORT_LAST = 13'(rws_pkg::RWS_SHORT_CYC - 1);
	localparam logic [5:0] DRIVE_LAST = 6'(rws_pkg::RWS_DRIVE_CYC - 1);
	localparam logic [5:0] HOLD_LAST = 6'(rws_pkg::RWS_HOLD_CYC - 1);
	localparam logic [12:0] PIN_MIN = 13'(rws_pkg::RWS_PIN_MIN_CYC);
	localparam logic [12:0] PIN_MIN_LONG = 13'(PIN_MIN_LONG_CYC);

	typedef struct packed {
		rws_pkg::rws_state_e st;
		logic [12:0] cnt;
		logic [5:0] phase;
		logic [12:0] pin_lo;
		logic long_src;
		logic por_prev;
		logic lvd_prev;
		logic [3:0] s1;
		logic [3:0] s2;
		logic [3:0] s3;
		logic [3:0] filt;
		logic [7:0] cause;
		logic [3:0] ctrl;
		logic pin_oe;
		logic internal_reset;
		logic [15:0] vec;
		logic core_en;
		logic mod_en;
		logic bus_en;
		logic tick;
		logic clr;
		logic wdt_en;
		logic ack;
		logic [31:0] dat;
	} rws_state_s;

	rws_state_s q;
	rws_state_s d;
	logic wdt_ok;
	logic wdt_evt;
	logic opc_evt;
	logic adr_evt;
	logic pin_low;
	logic wb_req;
	logic wb_wr;
	logic svc_wr;
	logic [12:0] pin_thr;

	////////////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		d = q;
		// three stage synchronisers, accepted once stages two and three agree
		d.s1 = {irq_hv_i, rst_hv_i, wdt_ovf_i, rst_pin_i}; // RQ23
		d.s2 = q.s1;
		d.s3 = q.s2;
		d.filt = (q.s2 & q.s3) | (q.filt & (q.s2 | q.s3)); // RQ23
		d.por_prev = por_i;
		d.lvd_prev = lvd_i;
		d.tick = 1'b0;
		d.clr = 1'b0;
		d.ack = 1'b0;
		d.dat = 32'h0000_0000;

		// watchdog gating from elevated test voltages
		wdt_ok = !((q.ctrl[rws_pkg::RWS_CTRL_MON] & (q.filt[rws_pkg::RWS_SYN_RHV]
			| q.filt[rws_pkg::RWS_SYN_IHV]))
			| (q.ctrl[rws_pkg::RWS_CTRL_BRK] & q.filt[rws_pkg::RWS_SYN_RHV])); // RQ16
		d.wdt_en = wdt_ok;

		// internal reset events
		wdt_evt = d.filt[rws_pkg::RWS_SYN_WDT] & !q.filt[rws_pkg::RWS_SYN_WDT]
			& q.wdt_en; // RQ13
		opc_evt = core_i.illegal_op
			| (core_i.stop_exec & !q.ctrl[rws_pkg::RWS_CTRL_HALT]); // RQ17 RQ18
		adr_evt = core_i.fetch & core_i.unmapped; // RQ19
		pin_low = !q.filt[rws_pkg::RWS_SYN_PIN];
		wb_req = wb_cyc_i & wb_stb_i & !q.ack;
		// writes land at the edge where the master sees ack high
		wb_wr = wb_cyc_i & wb_stb_i & wb_we_i & q.ack;
		svc_wr = (wb_wr & (wb_adr_i == rws_pkg::RWS_OFS_SERVICE))
			| (core_i.wr & (core_i.addr == rws_pkg::RWS_SVC_ADDR));

		// free running prescaler, overflow clocks the watchdog
		d.cnt = q.cnt + 13'h0001; // RQ21
		if (q.cnt == 13'h1fff) begin
			d.tick = 1'b1; // RQ15 RQ21
		end
		if (svc_wr) begin
			d.cnt[12:rws_pkg::RWS_SVC_LOW_BIT] = '0; // RQ14
			d.clr = 1'b1; // RQ14
		end

		// pin low duration, measured on the synchronised level
		pin_thr = q.long_src ? PIN_MIN_LONG : PIN_MIN; // RQ7
		if (!pin_low) begin
			d.pin_lo = 13'h0000;
		end else if (q.pin_lo != 13'h1fff) begin
			d.pin_lo = q.pin_lo + 13'h0001;
		end
		if (pin_low && d.filt[rws_pkg::RWS_SYN_PIN] && d.pin_lo >= pin_thr) begin
			d.cause[rws_pkg::RWS_CAUSE_PIN] = 1'b1; // RQ6 RQ7
		end

		// sequencer
		unique case (q.st)
			rws_pkg::RWS_RUN: begin
				if (core_i.stop_exec && q.ctrl[rws_pkg::RWS_CTRL_HALT]) begin
					d.st = rws_pkg::RWS_STOP;
					d.cnt = 13'h0000; // RQ22
				end else if (core_i.wait_exec) begin
					d.st = rws_pkg::RWS_WAIT; // RQ2
				end
			end
			rws_pkg::RWS_WAIT: begin
				if (wake_i) begin
					d.st = rws_pkg::RWS_RUN;
				end
			end
			rws_pkg::RWS_STOP: begin
				d.cnt = 13'h0000; // RQ22
				if (wake_i) begin
					d.st = rws_pkg::RWS_RECOV; // RQ1
				end
			end
			rws_pkg::RWS_RECOV: begin
				if (q.cnt == (q.ctrl[rws_pkg::RWS_CTRL_SHORT] ? SHORT_LAST : LONG_LAST)) begin
					d.st = rws_pkg::RWS_RUN; // RQ1 RQ22
				end
			end
			rws_pkg::RWS_LONG: begin
				if (q.cnt == LONG_LAST) begin
					d.st = rws_pkg::RWS_DRIVE; // RQ9 RQ10 RQ20
					d.phase = 6'h00;
				end
			end
			rws_pkg::RWS_DRIVE: begin
				d.phase = q.phase + 6'h01;
				if (q.phase == DRIVE_LAST) begin
					d.st = rws_pkg::RWS_HOLD; // RQ8
					d.phase = 6'h00;
				end
			end
			rws_pkg::RWS_HOLD: begin
				d.phase = q.phase + 6'h01;
				if (q.phase == HOLD_LAST) begin
					d.st = rws_pkg::RWS_RUN; // RQ8 RQ10
					d.long_src = 1'b0;
				end
			end
			rws_pkg::RWS_EXT: begin
				if (!pin_low) begin
					d.st = rws_pkg::RWS_HOLD;
					d.phase = 6'h00;
				end
			end
			default: begin
				d.st = rws_pkg::RWS_RUN;
			end
		endcase

		// reset entry from any running or sleeping state
		if (q.st inside {rws_pkg::RWS_RUN, rws_pkg::RWS_WAIT, rws_pkg::RWS_STOP,
			rws_pkg::RWS_RECOV}) begin
			if (pin_low) begin
				d.st = rws_pkg::RWS_EXT; // RQ5
			end else if (wdt_evt || (q.st == rws_pkg::RWS_RUN && (opc_evt || adr_evt))) begin
				d.st = rws_pkg::RWS_DRIVE; // RQ8
				d.phase = 6'h00;
				d.cnt = 13'h0000; // RQ5
				if (wdt_evt) begin
					d.cause[rws_pkg::RWS_CAUSE_WDT] = 1'b1; // RQ6 RQ13
				end
				if (q.st == rws_pkg::RWS_RUN && opc_evt) begin
					d.cause[rws_pkg::RWS_CAUSE_OPC] = 1'b1; // RQ6 RQ17
				end
				if (q.st == rws_pkg::RWS_RUN && adr_evt) begin
					d.cause[rws_pkg::RWS_CAUSE_ADR] = 1'b1; // RQ6 RQ19
				end
			end
		end

		// power-on and low voltage restart the long sequence while present
		if (por_i || lvd_i) begin
			d.st = rws_pkg::RWS_LONG; // RQ9
			d.cnt = 13'h0000; // RQ5
			d.long_src = 1'b1;
			if (por_i && !q.por_prev) begin
				d.cause = rws_pkg::RWS_CAUSE_POR_ONLY; // RQ12
			end
			if (lvd_i && !q.lvd_prev) begin
				d.cause[rws_pkg::RWS_CAUSE_LVI] = 1'b1; // RQ6 RQ20
			end
		end

		// control register write, defaults while in internal reset
		if (wb_wr && wb_sel_i[0] && (wb_adr_i == rws_pkg::RWS_OFS_CTRL)) begin
			d.ctrl = wb_dat_i[3:0];
		end
		if (d.st inside {rws_pkg::RWS_LONG, rws_pkg::RWS_DRIVE, rws_pkg::RWS_HOLD,
			rws_pkg::RWS_EXT}) begin
			d.ctrl = rws_pkg::RWS_CTRL_RST; // RQ4
		end

		// wishbone reads, unmapped reads return zero
		if (wb_req) begin
			d.ack = 1'b1;
			if (!wb_we_i) begin
				unique case (wb_adr_i)
					rws_pkg::RWS_OFS_CAUSE: d.dat = {24'h00_0000, q.cause};
					rws_pkg::RWS_OFS_CTRL: d.dat = {28'h000_0000, q.ctrl};
					rws_pkg::RWS_OFS_STATUS: d.dat = {8'h00, q.st, 3'h0, q.cnt};
					default: d.dat = 32'h0000_0000;
				endcase
			end
		end

		// registered outputs from the next state
		d.internal_reset = d.st inside {rws_pkg::RWS_LONG, rws_pkg::RWS_DRIVE, rws_pkg::RWS_HOLD,
			rws_pkg::RWS_EXT}; // RQ3
		d.pin_oe = d.st inside {rws_pkg::RWS_LONG, rws_pkg::RWS_DRIVE}; // RQ8 RQ10
		d.vec = d.ctrl[rws_pkg::RWS_CTRL_MON] ? rws_pkg::RWS_VEC_MON
			: rws_pkg::RWS_VEC_USER; // RQ3
		d.mod_en = d.st inside {rws_pkg::RWS_RUN, rws_pkg::RWS_WAIT, rws_pkg::RWS_DRIVE,
			rws_pkg::RWS_HOLD, rws_pkg::RWS_EXT}; // RQ2 RQ11
		d.core_en = d.st inside {rws_pkg::RWS_RUN, rws_pkg::RWS_DRIVE, rws_pkg::RWS_HOLD,
			rws_pkg::RWS_EXT}; // RQ1 RQ11
		d.bus_en = d.st != rws_pkg::RWS_STOP; // RQ11
	end

	////////////////////////////////////////////////////////////////////////////
	// state register, clk_i rises on the reference clock falling edge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			// synchronisers start at the idle pin levels, so no false edge follows
			q <= '{st: rws_pkg::RWS_RUN, s1: 4'h1, s2: 4'h1, s3: 4'h1, filt: 4'h1,
				cause: rws_pkg::RWS_CAUSE_RST, ctrl: rws_pkg::RWS_CTRL_RST,
				vec: rws_pkg::RWS_VEC_USER, core_en: 1'b1, mod_en: 1'b1, bus_en: 1'b1,
				wdt_en: 1'b1, default: '0};
		end else begin
			q <= d;
		end
	end

	// outputs straight from flip-flops, except the pin level, which is tied low
	assign wb_dat_o = q.dat;
	assign wb_ack_o = q.ack;
	assign rst_pin_o = 1'b0;
	assign rst_pin_oe_o = q.pin_oe;
	assign internal_reset_o = q.internal_reset;
	assign vector_addr_o = q.vec;
	assign core_clk_en_o = q.core_en;
	assign module_clk_en_o = q.mod_en;
	assign bus_clock_source_en_o = q.bus_en;
	assign wdt_tick_o = q.tick;
	assign wdt_clear_o = q.clr;
	assign wdt_enable_o = q.wdt_en;

	////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_drive_entry;
		$rose(q.st == rws_pkg::RWS_DRIVE) && !por_i && !lvd_i;
	endsequence
	sequence s_drive_run;
		##31 (q.st == rws_pkg::RWS_DRIVE && q.pin_oe) ##1 (q.st == rws_pkg::RWS_HOLD);
	endsequence

	a_drive_span: assert property (s_drive_entry |-> s_drive_run) // RQ8
		else $error("pin drive phase not 32 cycles");
	a_hold_span: assert property ($rose(q.st == rws_pkg::RWS_HOLD) // RQ8
		&& !por_i && !lvd_i && !pin_low |-> ##31 q.internal_reset
		##1 (!q.internal_reset || por_i || lvd_i || pin_low))
		else $error("internal hold phase not 32 cycles");
	a_long_end: assert property (q.st == rws_pkg::RWS_LONG && q.cnt == LONG_LAST // RQ9
		&& !por_i && !lvd_i |=> q.st == rws_pkg::RWS_DRIVE && q.pin_oe)
		else $error("long count did not end at 4096");
	a_long_clocks: assert property (q.st == rws_pkg::RWS_LONG |-> q.pin_oe // RQ11
		&& q.internal_reset && !q.core_en && !q.mod_en && q.bus_en)
		else $error("clock gating wrong during long count");
	a_por_flags: assert property ($rose(por_i) |=> q.cause[7:2] == 6'h20 // RQ12
		&& q.cause[0] == 1'b0)
		else $error("power-on flag pattern wrong");
	a_wdt_tick: assert property (q.cnt == 13'h1fff |=> q.tick) // RQ15
		else $error("watchdog tick missing on overflow");
	a_stop_clear: assert property (q.st == rws_pkg::RWS_STOP // RQ22
		|-> q.cnt == 13'h0000 && !q.core_en && !q.bus_en)
		else $error("prescaler not held clear in deep sleep");
	a_light_sleep: assert property (q.st == rws_pkg::RWS_WAIT |-> !q.core_en && q.mod_en) // RQ2
		else $error("light sleep clock gating wrong");
	a_wake_short: assert property (q.st == rws_pkg::RWS_RECOV && q.cnt == SHORT_LAST // RQ1
		&& q.ctrl[rws_pkg::RWS_CTRL_SHORT] && !pin_low && !por_i && !lvd_i && !wdt_evt
		|=> q.st == rws_pkg::RWS_RUN)
		else $error("short wake delay wrong");
	a_bad_opcode: assert property (q.st == rws_pkg::RWS_RUN && core_i.illegal_op // RQ17
		&& !pin_low && !por_i && !lvd_i |=> q.cause[rws_pkg::RWS_CAUSE_OPC]
		&& q.st == rws_pkg::RWS_DRIVE && q.cnt == 13'h0000)
		else $error("illegal opcode reset missing");
	a_service: assert property (core_i.wr && core_i.addr == rws_pkg::RWS_SVC_ADDR // RQ14
		&& q.st == rws_pkg::RWS_RUN && !pin_low && !por_i && !lvd_i && !wdt_evt
		&& !opc_evt && !adr_evt && !core_i.stop_exec
		|=> q.clr && q.cnt[12:4] == 9'h000)
		else $error("service write did not clear prescaler");

	// pin flag, prescaler under pin reset, defaults in reset, watchdog entry
	a_pin_flag: assert property ($rose(q.st == rws_pkg::RWS_HOLD) && !q.long_src // RQ7
		&& $past(q.pin_lo) >= PIN_MIN |-> q.cause[rws_pkg::RWS_CAUSE_PIN])
		else $error("pin flag missing after long pin low");
	a_ext_count: assert property (q.st == rws_pkg::RWS_EXT && !por_i && !lvd_i // RQ5
		&& !svc_wr |=> q.cnt == $past(q.cnt) + 13'h0001)
		else $error("pin reset disturbed the prescaler");
	a_reset_defaults: assert property (q.internal_reset |-> q.ctrl == rws_pkg::RWS_CTRL_RST // RQ4
		&& q.vec == rws_pkg::RWS_VEC_USER)
		else $error("registers not at defaults during internal reset");
	a_wdt_reset: assert property (q.st == rws_pkg::RWS_RUN && wdt_evt && !pin_low // RQ13
		&& !por_i && !lvd_i |=> q.cause[rws_pkg::RWS_CAUSE_WDT]
		&& q.st == rws_pkg::RWS_DRIVE)
		else $error("watchdog overflow did not reset");

endmodule

/* File: rws_pkg.sv */
package rws_pkg;

	////////////////////////////////////////////////////////////////////////////
	// register map, byte addresses on the wishbone port
	localparam logic [7:0] RWS_OFS_CAUSE = 8'h00;
	localparam logic [7:0] RWS_OFS_CTRL = 8'h04;
	localparam logic [7:0] RWS_OFS_STATUS = 8'h08;
	localparam logic [7:0] RWS_OFS_SERVICE = 8'h0c;

	// reset cause register bit positions
	localparam int RWS_CAUSE_POR = 7;
	localparam int RWS_CAUSE_PIN = 6;
	localparam int RWS_CAUSE_WDT = 5;
	localparam int RWS_CAUSE_OPC = 4;
	localparam int RWS_CAUSE_ADR = 3;
	localparam int RWS_CAUSE_LVI = 1;
	localparam logic [7:0] RWS_CAUSE_RST = 8'h00;
	localparam logic [7:0] RWS_CAUSE_POR_ONLY = 8'h80;

	// control register bit positions and values after reset
	localparam int RWS_CTRL_SHORT = 0;
	localparam int RWS_CTRL_HALT = 1;
	localparam int RWS_CTRL_MON = 2;
	localparam int RWS_CTRL_BRK = 3;
	localparam logic [3:0] RWS_CTRL_RST = 4'h0;

	// status register field position
	localparam int RWS_STAT_STATE = 16;

	// reference clock cycle counts and the low bit of the service clear
	localparam int RWS_LONG_CYC = 4096;
	localparam int RWS_SHORT_CYC = 32;
	localparam int RWS_DRIVE_CYC = 32;
	localparam int RWS_HOLD_CYC = 32;
	localparam int RWS_PIN_MIN_CYC = 67;
	localparam int RWS_PIN_MIN_LONG_CYC = 4163;
	localparam int RWS_SVC_LOW_BIT = 4;

	// core address space constants
	localparam logic [15:0] RWS_SVC_ADDR = 16'hffff;
	localparam logic [15:0] RWS_VEC_USER = 16'hfffe;
	localparam logic [15:0] RWS_VEC_MON = 16'hfefe;

	// synchroniser lanes
	localparam int RWS_SYN_PIN = 0;
	localparam int RWS_SYN_WDT = 1;
	localparam int RWS_SYN_RHV = 2;
	localparam int RWS_SYN_IHV = 3;

	typedef enum logic [7:0] {
		RWS_RUN = 8'h01,
		RWS_LONG = 8'h02,
		RWS_DRIVE = 8'h04,
		RWS_HOLD = 8'h08,
		RWS_EXT = 8'h10,
		RWS_STOP = 8'h20,
		RWS_RECOV = 8'h40,
		RWS_WAIT = 8'h80
	} rws_state_e;

	// core side event group
	typedef struct packed {
		logic fetch;
		logic unmapped;
		logic illegal_op;
		logic stop_exec;
		logic wait_exec;
		logic wr;
		logic [15:0] addr;
	} rws_core_s;

endpackage

/* File: rws_pin_partner.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// external chip sharing the open-drain reset line, pulled up when released
module rws_pin_partner (
	input wire logic clk_i,
	input wire logic dev_low_i,
	input wire logic go_i,
	input wire logic [15:0] low_cyc_i,
	output logic pin_o
);
	logic [15:0] low_q = 16'h0;

	// hold the line low for the commanded number of reference cycles
	always_ff @(posedge clk_i) begin
		if (go_i)
			low_q <= low_cyc_i;
		else if (low_q != 16'h0)
			low_q <= low_q - 16'h1;
	end

	// wired-and of both parties, pull-up wins when nobody drives
	assign pin_o = ~(dev_low_i | (low_q != 16'h0));
endmodule

/* File: rws_sequencer_tb.sv */
`timescale 1ns/1ps
module rws_sequencer_tb;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [7:0] adr = 8'h0;
	logic [31:0] wdat = 32'h0;
	logic we = 1'b0, cyc = 1'b0, stb = 1'b0, go = 1'b0;
	logic por = 1'b0, lvd = 1'b0, wdt_ovf = 1'b0, rhv = 1'b0, ihv = 1'b0, wake = 1'b0;
	logic [15:0] low_cyc = 16'h0;
	rws_pkg::rws_core_s core = '0;
	logic [31:0] wb_dat_o, rd;
	logic wb_ack_o, pin, pin_o, pin_oe, internal_reset, core_en, mod_en, bus_en, tick, clr, wdt_en;
	logic [15:0] vec;
	logic [2:0] snap;
	logic [7:0] cause = 8'h80;
	logic [31:0] exp_q[$], msk_q[$];
	int bad_count = 0, n_checks = 0, n_clr = 0, n_tick = 0, oe_n, ir_n, c, k;
	int cb[5] = '{rws_pkg::RWS_CAUSE_OPC, rws_pkg::RWS_CAUSE_ADR, rws_pkg::RWS_CAUSE_WDT,
		rws_pkg::RWS_CAUSE_OPC, rws_pkg::RWS_CAUSE_LVI};

	rws_sequencer rws_sequencer_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr),
		.wb_dat_i(wdat), .wb_sel_i(4'hf), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .por_i(por), .lvd_i(lvd),
		.wdt_ovf_i(wdt_ovf), .rst_pin_i(pin), .rst_hv_i(rhv), .irq_hv_i(ihv), .wake_i(wake),
		.core_i(core), .rst_pin_o(pin_o), .rst_pin_oe_o(pin_oe), .internal_reset_o(internal_reset),
		.vector_addr_o(vec), .core_clk_en_o(core_en), .module_clk_en_o(mod_en),
		.bus_clock_source_en_o(bus_en), .wdt_tick_o(tick), .wdt_clear_o(clr),
		.wdt_enable_o(wdt_en));
	rws_pin_partner rws_pin_partner_inst (.clk_i(clk_i), .dev_low_i(pin_oe & ~pin_o),
		.go_i(go), .low_cyc_i(low_cyc), .pin_o(pin));

	////////////////////////////////////////////////////////////////////////////
	// reference clock, 40 ns period
	initial forever #20 clk_i = ~clk_i;

	task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task final_report;
		if (bad_count == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// classic single wishbone cycle, expectation noted before the request
	task wb(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [31:0] e,
		input logic [31:0] m);
		exp_q.push_back(e);
		msk_q.push_back(m);
		@(posedge clk_i);
		adr <= a;
		we <= w;
		wdat <= d;
		cyc <= 1'b1;
		stb <= 1'b1;
		@(posedge clk_i);
		while (wb_ack_o !== 1'b1) @(posedge clk_i);
		rd = wb_dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	// raise one reset source: 0 opcode, 1 fetch, 2 watchdog, 3 stop, 4 low volt, 5 power
	task fire(input int s);
		@(posedge clk_i);
		case (s)
			0: core.illegal_op <= 1'b1;
			1: begin
				core.fetch <= 1'b1;
				core.unmapped <= 1'b1;
			end
			2: wdt_ovf <= 1'b1;
			3: core.stop_exec <= 1'b1;
			4: lvd <= 1'b1;
			default: por <= 1'b1;
		endcase
		repeat ((s == 2) ? 4 : 1) @(posedge clk_i);
		core <= '0;
		wdt_ovf <= 1'b0;
		lvd <= 1'b0;
		por <= 1'b0;
	endtask

	// cycles with internal reset high, and with the pin driven among them
	task meas;
		k = 0;
		oe_n = 0;
		ir_n = 0;
		while (internal_reset !== 1'b1 && k < 20) begin
			@(posedge clk_i);
			k++;
		end
		while (internal_reset === 1'b1 && k < 9000) begin
			oe_n += (pin_oe === 1'b1);
			if (ir_n == 100)
				snap = {core_en, mod_en, bus_en};
			ir_n++;
			@(posedge clk_i);
			k++;
		end
	endtask

	task long_seq;
		check(oe_n >= 4128 && oe_n <= 4130, 1, "long drive");
		check(ir_n - oe_n, 32, "long hold");
		check(snap, 3'b001, "long clocks");
	endtask

	task sleep(input logic s);
		wb(rws_pkg::RWS_OFS_CTRL, 1'b1, {30'h0, 1'b1, s}, 32'h0, 32'h0);
		@(posedge clk_i);
		core.stop_exec <= 1'b1;
		@(posedge clk_i);
		core <= '0;
		repeat (3) @(posedge clk_i);
		check({core_en, mod_en, bus_en}, 3'b000, "stop clocks");
		wb(rws_pkg::RWS_OFS_STATUS, 1'b0, 32'h0, 32'h00200000, 32'h00ff1fff);
		@(posedge clk_i);
		wake <= 1'b1;
		@(posedge clk_i);
		wake <= 1'b0;
		k = 0;
		while (core_en !== 1'b1 && k < 5000) begin
			@(posedge clk_i);
			k++;
		end
		check(k >= (s ? 31 : 4095) && k <= (s ? 34 : 4098), 1, "wake delay");
	endtask

	////////////////////////////////////////////////////////////////////////////
	// scoreboard: oldest note against each acknowledged transfer
	always @(posedge clk_i) begin
		if (wb_ack_o === 1'b1) begin
			check(wb_dat_o & msk_q[0], exp_q[0], "read data");
			void'(exp_q.pop_front());
			void'(msk_q.pop_front());
		end
	end

	// pulse counters for watchdog service and tick
	always @(posedge clk_i) begin
		n_clr += (clr === 1'b1);
		n_tick += (tick === 1'b1);
	end

	// hang guard
	initial begin
		repeat (60000) @(posedge clk_i);
		bad_count++;
		final_report;
	end

	// main sequence
	initial begin
		void'($urandom(53));
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(rws_pkg::RWS_OFS_CAUSE, 1'b0, 32'h0, 32'h0, 32'hff);
		wb(rws_pkg::RWS_OFS_STATUS, 1'b0, 32'h0, 32'h00010000, 32'h00ff0000);
		wb(8'h40, 1'b0, 32'h0, 32'h0, 32'hffffffff);
		fire(5);
		meas;
		long_seq;
		wb(rws_pkg::RWS_OFS_CAUSE, 1'b0, 32'h0, 32'h80, 32'hff);
		for (int s = 0; s < 5; s++) begin
			repeat ($urandom_range(8)) @(posedge clk_i);
			wb(rws_pkg::RWS_OFS_CTRL, 1'b1, 32'h4, 32'h0, 32'h0);
			repeat (2) @(posedge clk_i);
			check({16'h0, vec}, 32'hfefe, "monitor vector");
			fire(s);
			meas;
			if (s == 4)
				long_seq;
			else begin
				check(oe_n, 32, "drive span");
				check(ir_n, 64, "hold span");
			end
			cause = cause | (8'h1 << cb[s]);
			wb(rws_pkg::RWS_OFS_CAUSE, 1'b0, 32'h0, {24'h0, cause}, 32'hff);
			wb(rws_pkg::RWS_OFS_CTRL, 1'b0, 32'h0, 32'h0, 32'hf);
			check({16'h0, vec}, 32'hfffe, "user vector");
		end
		core.unmapped <= 1'b1;
		@(posedge clk_i);
		core <= '0;
		repeat (10) @(posedge clk_i);
		check(internal_reset, 1'b0, "data access");
		fire(0);
		meas;
		repeat (400) @(posedge clk_i);
		for (int p = 0; p < 2; p++) begin
			low_cyc <= p ? 16'h43 : 16'h42;
			go <= 1'b1;
			@(posedge clk_i);
			go <= 1'b0;
			meas;
			check(oe_n, 0, "pin drive");
			check(pin_o, 1'b0, "pin level");
			cause = cause | (p ? 8'h40 : 8'h00);
			wb(rws_pkg::RWS_OFS_CAUSE, 1'b0, 32'h0, {24'h0, cause}, 32'hff);
		end
		wb(rws_pkg::RWS_OFS_STATUS, 1'b0, 32'h0, 32'h00010000, 32'h00ff0000);
		check(rd[12:0] > 13'd450, 1, "counter kept");
		c = n_clr;
		wb(rws_pkg::RWS_OFS_SERVICE, 1'b1, $urandom, 32'h0, 32'h0);
		wb(rws_pkg::RWS_OFS_STATUS, 1'b0, 32'h0, 32'h00010000, 32'h00ff0000);
		check(rd[12:0] < 13'h18, 1, "service count");
		@(posedge clk_i);
		core.wr <= 1'b1;
		core.addr <= rws_pkg::RWS_SVC_ADDR;
		@(posedge clk_i);
		core <= '0;
		repeat (4) @(posedge clk_i);
		check(n_clr, c + 2, "service pulses");
		c = n_tick;
		k = 0;
		while (n_tick == c && k < 8300) begin
			@(posedge clk_i);
			k++;
		end
		check(n_tick > c, 1, "tick");
		sleep(1'b1);
		sleep(1'b0);
		core.wait_exec <= 1'b1;
		@(posedge clk_i);
		core <= '0;
		repeat (3) @(posedge clk_i);
		check({core_en, mod_en}, 2'b01, "light sleep");
		wake <= 1'b1;
		@(posedge clk_i);
		wake <= 1'b0;
		repeat (5) @(posedge clk_i);
		check(core_en, 1'b1, "light wake");
		for (int h = 0; h < 4; h++) begin
			wb(rws_pkg::RWS_OFS_CTRL, 1'b1, h[1] ? 32'h8 : 32'h4, 32'h0, 32'h0);
			rhv <= ~h[0];
			ihv <= h[0];
			repeat (6) @(posedge clk_i);
			check(wdt_en, h == 3, "test voltage");
			rhv <= 1'b0;
			ihv <= 1'b0;
		end
		final_report;
	end
endmodule
